// file: cidf_defines.vh
`ifndef CIDF_DEFINES_VH
`define CIDF_DEFINES_VH

// ==========================================================================
// register addresses, as carried by the read/write register commands
// ==========================================================================
`define CIDF_ADDR_W          8
`define CIDF_ID_BASE         8'h14
`define CIDF_ID_LAST         8'h2b
`define CIDF_ID_ENTRIES      24
`define CIDF_ADDR_FLAGS      8'h2c

// byte position inside each four-byte identifier group
`define CIDF_BYTE_STD_HIGH   2'h0
`define CIDF_BYTE_STD_LOW    2'h1
`define CIDF_BYTE_EXT_MID    2'h2
`define CIDF_BYTE_EXT_LOW    2'h3

// group numbers: mask, filter 0, filter 1, transmit identifiers 0 to 2
`define CIDF_GRP_MASK        3'h0
`define CIDF_GRP_FILT0       3'h1
`define CIDF_GRP_FILT1       3'h2
`define CIDF_GRP_TX0         3'h3

// ==========================================================================
// field layouts
// ==========================================================================
`define CIDF_STD_LOW_WMASK   8'heb
`define CIDF_MASK_EXT_WMASK  8'hf8
`define CIDF_FULL_WMASK      8'hff
`define CIDF_SIDL_SID_HI     7
`define CIDF_SIDL_SID_LO     5
`define CIDF_SIDL_FRAME_TYPE_SELECT      3
`define CIDF_SIDL_EID_HI     1
`define CIDF_SIDL_EID_LO     0
`define CIDF_SID3_POS        3
`define CIDF_LOW3_ZERO       3'h0
`define CIDF_LOW3_ONES       3'h7
`define CIDF_RESET_BYTE      8'h00

// ==========================================================================
// error flag register
// ==========================================================================
`define CIDF_FLG_STATE_CHG   7
`define CIDF_FLG_RX_OVF      6
`define CIDF_FLG_BUS_OFF     5
`define CIDF_FLG_TX_PASS     4
`define CIDF_FLG_RX_PASS     3
`define CIDF_FLG_TX_WARN     2
`define CIDF_FLG_RX_WARN     1
`define CIDF_FLG_ANY_WARN    0
`define CIDF_FLAGS_RESET     8'h00

// error counter thresholds
`define CIDF_TEC_W           9
`define CIDF_REC_W           8
`define CIDF_TEC_BUS_OFF     9'h100
`define CIDF_TEC_PASSIVE     9'h080
`define CIDF_TEC_WARNING     9'h060
`define CIDF_REC_PASSIVE     8'h80
`define CIDF_REC_WARNING     8'h60

`endif

// file: cidf_id_filter_flags.v
`include "cidf_defines.vh"
`default_nettype none

module cidf_id_filter_flags (
  input  wire                     i_clk_sys,            // system clock, 25 MHz
  input  wire                     i_rst_n,              // asynchronous reset, active low
  // register command port
  input  wire [`CIDF_ADDR_W-1:0]  i_reg_addr,           // register address of the command
  input  wire                     i_reg_wr,             // write register strobe
  input  wire [7:0]               i_reg_wdata,          // write data
  input  wire                     i_reg_rd,             // read register strobe
  output reg  [7:0]               o_reg_rdata,          // read data, held until next read
  output reg                      o_reg_rvalid,         // one-cycle read answer pulse
  // option input
  input  wire                     i_message_type_option, // option bit: standard bit 3 ignored
  // received frame identifier
  input  wire                     i_rx_valid,           // one-cycle pulse: identifier present
  input  wire                     i_rx_ide,             // frame carries extended identifier
  input  wire [10:0]              i_rx_sid,             // standard identifier bits
  input  wire [17:0]              i_rx_eid,             // extended identifier bits
  output reg                      o_rx_done,            // one-cycle pulse: verdict ready
  output reg                      o_accept_info,        // accepted as information request
  output reg                      o_accept_input,       // accepted as input message
  // error counters and events
  input  wire [`CIDF_TEC_W-1:0]   i_tec,                // transmit error counter
  input  wire [`CIDF_REC_W-1:0]   i_rec,                // receive error counter
  input  wire                     i_rx_overflow,        // pulse: receive buffer overflow
  input  wire                     i_bus_recovered,      // pulse: bus recovery sequence done
  input  wire                     i_flags_ack,          // pulse: state change and overflow taken
  output reg  [7:0]               o_bus_error_flags,    // error flag register
  // transmit identifier low extended bytes
  output reg  [23:0]              o_tx_ident_ext_low    // three transmit bytes, tx0 lowest
);

  // ========================================================================
  // identifier register store
  // ========================================================================
  // twenty-four bytes in six groups of four: mask, filter 0, filter 1,
  // then the three transmit identifiers; each group is laid out as
  // standard high, standard low, extended mid and extended low.
  // the store is small enough to live in plain flip-flops, so every
  // byte is visible to the compare logic at once with no read port.
  reg  [7:0]  id_q [0:`CIDF_ID_ENTRIES-1];
  wire [7:0]  id_wmask [0:`CIDF_ID_ENTRIES-1];
  wire        id_hit;
  wire [7:0]  id_off;
  wire [4:0]  id_index;
  integer     k;

  // address decode: only the identifier window is writable; the flag
  // register and any unmapped address fall outside id_hit, so a write
  // there is dropped without touching the store
  assign id_hit   = (i_reg_addr >= `CIDF_ID_BASE) && (i_reg_addr <= `CIDF_ID_LAST);
  assign id_off   = i_reg_addr - `CIDF_ID_BASE;
  assign id_index = id_hit ? id_off[4:0] : 5'h00;

  // per-entry write mask keeps empty bits at zero
  // masking on the way in means the compare logic never sees a stray
  // one in an empty position; the mask's low three extended bits are
  // still zeroed a second time where the bytes are used
  genvar g;
  generate
    for (g = 0; g < `CIDF_ID_ENTRIES; g = g + 1)
    begin : g_wmask
      if (g % 4 == `CIDF_BYTE_STD_LOW)
      begin : g_std_low
        assign id_wmask[g] = `CIDF_STD_LOW_WMASK;
      end
      else if (g == `CIDF_BYTE_EXT_LOW)
      begin : g_mask_ext_low
        assign id_wmask[g] = `CIDF_MASK_EXT_WMASK;
      end
      else
      begin : g_full
        assign id_wmask[g] = `CIDF_FULL_WMASK;
      end
    end
  endgenerate

  // register writes from the write register command
  // a read and a write to the same byte in one cycle return the old
  // byte, as the read path samples the store before this edge lands
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (k = 0; k < `CIDF_ID_ENTRIES; k = k + 1)
      begin
        id_q[k] <= `CIDF_RESET_BYTE;
      end
    end
    else if (i_reg_wr && id_hit)
    begin
      id_q[id_index] <= i_reg_wdata & id_wmask[id_index];
    end
  end

  // ========================================================================
  // effective acceptance mask
  // ========================================================================
  wire [10:0] msk_sid_cfg;
  wire [10:0] msk_sid;
  wire [17:0] msk_eid;
  wire        msk_frame_type_select;
  wire [7:0]  msk_sidh;
  wire [7:0]  msk_sidl;

  // the mask is shaped here once and shared by both filters, so the
  // option and frame-type overrides cannot drift between the two
  // compare paths; the override depends on the incoming frame's type,
  // which makes this part combinational on the received identifier

  assign msk_sidh    = id_q[{`CIDF_GRP_MASK, `CIDF_BYTE_STD_HIGH}];
  assign msk_sidl    = id_q[{`CIDF_GRP_MASK, `CIDF_BYTE_STD_LOW}];
  assign msk_frame_type_select   = msk_sidl[`CIDF_SIDL_FRAME_TYPE_SELECT];
  assign msk_sid_cfg = {msk_sidh, msk_sidl[`CIDF_SIDL_SID_HI:`CIDF_SIDL_SID_LO]};

  // standard bit 3 forced off by the option, low three bits by frame type
  assign msk_sid[10:4] = msk_sid_cfg[10:4];
  assign msk_sid[3]    = i_message_type_option ? 1'b0 : msk_sid_cfg[3];
  assign msk_sid[2:0]  = i_rx_ide ? msk_sid_cfg[2:0] : `CIDF_LOW3_ZERO;

  // low three extended bits never take part in the compare
  assign msk_eid = {msk_sidl[`CIDF_SIDL_EID_HI:`CIDF_SIDL_EID_LO],
                    id_q[{`CIDF_GRP_MASK, `CIDF_BYTE_EXT_MID}],
                    id_q[{`CIDF_GRP_MASK, `CIDF_BYTE_EXT_LOW}][7:3],
                    `CIDF_LOW3_ZERO};

  // ========================================================================
  // two acceptance filters
  // ========================================================================
  wire [1:0]  filt_hit;

  // filter 0 answers information requests and filter 1 input messages;
  // both are evaluated in parallel on the same identifier, and a frame
  // may hit both when their patterns overlap under the mask. the user
  // must keep the two patterns apart if one verdict per frame is wanted.
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_filt
      localparam [2:0] GRP = `CIDF_GRP_FILT0 + g;
      wire [7:0]  f_sidh;
      wire [7:0]  f_sidl;
      wire        f_frame_type_select;
      wire [10:0] f_sid;
      wire [17:0] f_eid;
      wire [10:0] care_sid;
      wire [17:0] care_eid;
      wire        sid_ok;
      wire        eid_ok;
      wire        type_ok;

      assign f_sidh  = id_q[{GRP, `CIDF_BYTE_STD_HIGH}];
      assign f_sidl  = id_q[{GRP, `CIDF_BYTE_STD_LOW}];
      assign f_frame_type_select = f_sidl[`CIDF_SIDL_FRAME_TYPE_SELECT];
      assign f_sid   = {f_sidh, f_sidl[`CIDF_SIDL_SID_HI:`CIDF_SIDL_SID_LO]};
      assign f_eid   = {f_sidl[`CIDF_SIDL_EID_HI:`CIDF_SIDL_EID_LO],
                        id_q[{GRP, `CIDF_BYTE_EXT_MID}],
                        id_q[{GRP, `CIDF_BYTE_EXT_LOW}]};

      // bits that are compared: mask ones, less the filter's don't cares
      assign care_sid[10:4] = msk_sid[10:4];
      assign care_sid[3]    = msk_sid[3] & ~i_message_type_option;
      assign care_sid[2:0]  = msk_sid[2:0] &
                              (f_frame_type_select ? `CIDF_LOW3_ZERO : `CIDF_LOW3_ONES);
      assign care_eid       = {msk_eid[17:3], `CIDF_LOW3_ZERO};

      assign sid_ok  = ((i_rx_sid ^ f_sid) & care_sid) == 11'h000;
      // extended bits only exist in extended frames
      assign eid_ok  = !i_rx_ide || (((i_rx_eid ^ f_eid) & care_eid) == 18'h00000);
      // frame type compared only when the mask asks for it
      assign type_ok = !msk_frame_type_select || (i_rx_ide == f_frame_type_select);

      assign filt_hit[g] = sid_ok && eid_ok && type_ok;
    end
  endgenerate

  // verdict registered one cycle after the identifier
  // the accept bits hold between frames so a slow consumer can read
  // them late; only the done pulse marks a fresh verdict
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rx_done      <= 1'b0;
      o_accept_info  <= 1'b0;
      o_accept_input <= 1'b0;
    end
    else
    begin
      o_rx_done <= i_rx_valid;
      if (i_rx_valid)
      begin
        o_accept_info  <= filt_hit[0];
        o_accept_input <= filt_hit[1];
      end
    end
  end

  // ========================================================================
  // error flag register
  // ========================================================================
  wire        tx_warn;
  wire        rx_warn;
  wire        tx_pass;
  wire        rx_pass;
  wire        tx_off;
  wire [1:0]  err_state;
  reg  [1:0]  err_state_q;
  reg  [7:0]  flags_d;

  assign tx_off  = i_tec >= `CIDF_TEC_BUS_OFF;
  assign tx_pass = i_tec >= `CIDF_TEC_PASSIVE;
  assign rx_pass = i_rec >= `CIDF_REC_PASSIVE;
  assign tx_warn = i_tec >= `CIDF_TEC_WARNING;
  assign rx_warn = i_rec >= `CIDF_REC_WARNING;

  // thresholds are compared on the live counts every cycle, so the
  // count-derived bits carry no history; only the state change,
  // overflow and bus-off bits are sticky and need an explicit clear.
  // node state: 0 active, 1 passive, 2 bus off
  assign err_state = tx_off ? 2'h2 : ((tx_pass || rx_pass) ? 2'h1 : 2'h0);

  // next flag value; a set in the clearing cycle wins
  always @*
  begin
    flags_d = o_bus_error_flags;
    if (i_flags_ack)
    begin
      flags_d[`CIDF_FLG_STATE_CHG] = 1'b0;
      flags_d[`CIDF_FLG_RX_OVF]    = 1'b0;
    end
    if (err_state != err_state_q)
    begin
      flags_d[`CIDF_FLG_STATE_CHG] = 1'b1;
    end
    if (i_rx_overflow)
    begin
      flags_d[`CIDF_FLG_RX_OVF] = 1'b1;
    end
    if (i_bus_recovered)
    begin
      flags_d[`CIDF_FLG_BUS_OFF] = 1'b0;
    end
    if (tx_off)
    begin
      flags_d[`CIDF_FLG_BUS_OFF] = 1'b1;
    end
    flags_d[`CIDF_FLG_TX_PASS]  = tx_pass;
    flags_d[`CIDF_FLG_RX_PASS]  = rx_pass;
    flags_d[`CIDF_FLG_TX_WARN]  = tx_warn;
    flags_d[`CIDF_FLG_RX_WARN]  = rx_warn;
    flags_d[`CIDF_FLG_ANY_WARN] = tx_warn || rx_warn;
  end

  // flags refreshed every cycle
  // the previous state starts as active, so a node leaving reset with
  // counts already past a passive or bus-off threshold flags a state change at once
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bus_error_flags <= `CIDF_FLAGS_RESET;
      err_state_q       <= 2'h0;
    end
    else
    begin
      o_bus_error_flags <= flags_d;
      err_state_q       <= err_state;
    end
  end

  // ========================================================================
  // read path and transmit byte outputs
  // ========================================================================
  // read data is registered and held until the next read strobe, so the
  // answer stands beside the one-cycle valid pulse and after it; the
  // flag register is returned as it stood before the read edge
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd)
      begin
        if (id_hit)
        begin
          o_reg_rdata <= id_q[id_index];
        end
        else if (i_reg_addr == `CIDF_ADDR_FLAGS)
        begin
          o_reg_rdata <= o_bus_error_flags;
        end
        else
        begin
          o_reg_rdata <= 8'h00;
        end
      end
    end
  end

  // transmit low extended bytes handed to message generation
  // these run one cycle behind the store; a message started in the
  // same cycle as a write still goes out with the old byte
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_tx_ident_ext_low <= 24'h000000;
    end
    else
    begin
      o_tx_ident_ext_low <= {id_q[{`CIDF_GRP_TX0 + 3'h2, `CIDF_BYTE_EXT_LOW}],
                             id_q[{`CIDF_GRP_TX0 + 3'h1, `CIDF_BYTE_EXT_LOW}],
                             id_q[{`CIDF_GRP_TX0, `CIDF_BYTE_EXT_LOW}]};
    end
  end

endmodule

`default_nettype wire

// file: cidf_checker.sv
`default_nettype none
// ==========================================================
// watches register reads, frame verdicts and error flags
module cidf_checker (
  input wire logic       i_clk_sys,        // clock
  input wire logic       i_rst_n,          // reset, active low
  input wire logic [7:0] i_reg_addr,       // register address
  input wire logic       i_reg_rd,         // read strobe
  input wire logic [7:0] o_reg_rdata,      // read data
  input wire logic       o_reg_rvalid,     // read answer
  input wire logic       i_rx_valid,       // frame strobe
  input wire logic       o_rx_done,        // verdict strobe
  input wire logic [8:0] i_tec,            // transmit count
  input wire logic [7:0] i_rec,            // receive count
  input wire logic       i_rx_overflow,    // overflow pulse
  input wire logic [7:0] o_bus_error_flags // flag register
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] st;
  logic [1:0] st_q;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  // error state: 0 active, 1 passive, 2 bus off
  assign st = (i_tec >= 9'h100) ? 2'h2 : (i_tec >= 9'h080 || i_rec >= 8'h80) ? 2'h1 : 2'h0;
  // previous state, active after reset
  always @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n)
      st_q <= 2'h0;
    else
      st_q <= st;
  sequence s_rd_flags;
    i_reg_rd && i_reg_addr == 8'h2c;
  endsequence
  sequence s_rd_std_low;
    i_reg_rd && i_reg_addr >= 8'h14 && i_reg_addr <= 8'h2b && i_reg_addr[1:0] == 2'h1;
  endsequence
  property p_flags_ro;
    s_rd_flags |=> o_reg_rvalid && o_reg_rdata == $past(o_bus_error_flags);
  endproperty
  a_flags_ro: assert property (p_flags_ro) else $error("flag read mismatch");
  property p_std_low;
    s_rd_std_low |=> o_reg_rdata[4] == 1'b0 && o_reg_rdata[2] == 1'b0;
  endproperty
  a_std_low: assert property (p_std_low) else $error("empty bits read set");
  property p_mask_ext;
    i_reg_rd && i_reg_addr == 8'h17 |=> o_reg_rdata[2:0] == 3'h0;
  endproperty
  a_mask_ext: assert property (p_mask_ext) else $error("mask low bits set");
  property p_state_chg;
    st != st_q |=> o_bus_error_flags[7];
  endproperty
  a_state_chg: assert property (p_state_chg) else $error("state change missed");
  property p_overflow;
    i_rx_overflow |=> o_bus_error_flags[6];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow missed");
  property p_bus_off;
    i_tec >= 9'h100 |=> o_bus_error_flags[5];
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus off missed");
  property p_tx_pass;
    1'b1 |=> o_bus_error_flags[4] == ($past(i_tec) >= 9'h080);
  endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("tx passive wrong");
  property p_rx_pass;
    if (i_rec >= 8'h80) ##1 o_bus_error_flags[3] else ##1 !o_bus_error_flags[3];
  endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("rx passive wrong");
  property p_tx_warn;
    1'b1 |=> o_bus_error_flags[2] == ($past(i_tec) >= 9'h060);
  endproperty
  a_tx_warn: assert property (p_tx_warn) else $error("tx warning wrong");
  property p_rx_warn;
    if (i_rec >= 8'h60) ##1 o_bus_error_flags[1] else ##1 !o_bus_error_flags[1];
  endproperty
  a_rx_warn: assert property (p_rx_warn) else $error("rx warning wrong");
  property p_any_warn;
    o_bus_error_flags[0] == (o_bus_error_flags[1] || o_bus_error_flags[2]);
  endproperty
  a_any_warn: assert property (p_any_warn) else $error("any warning wrong");
  property p_verdict;
    i_rx_valid |=> o_rx_done;
  endproperty
  a_verdict: assert property (p_verdict) else $error("verdict missing");
endmodule
bind cidf_id_filter_flags cidf_checker i_cidf_checker (.i_clk_sys, .i_rst_n, .i_reg_addr, .i_reg_rd,
  .o_reg_rdata, .o_reg_rvalid, .i_rx_valid, .o_rx_done, .i_tec, .i_rec, .i_rx_overflow, .o_bus_error_flags);
`default_nettype wire

// file: cidf_partner.sv
`default_nettype none
// ==========================================================
// remote node presenting one received identifier per call
module cidf_partner (
  input  wire logic        i_clk_sys,  // clock
  output var  logic        o_rx_valid, // identifier strobe
  output var  logic        o_rx_ide,   // extended frame
  output var  logic [10:0] o_rx_sid,   // standard identifier
  output var  logic [17:0] o_rx_eid    // extended identifier
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle at time zero
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_ide = 1'b0;
    o_rx_sid = 11'h000;
    o_rx_eid = 18'h00000;
  end
  // hold over one edge, then invert idle lines so stale values never match
  task automatic send(input logic ide, input logic [10:0] sid, input logic [17:0] eid);
    o_rx_valid = 1'b1;
    o_rx_ide = ide;
    o_rx_sid = sid;
    o_rx_eid = eid;
    @(posedge i_clk_sys);
    #1;
    o_rx_valid = 1'b0;
    o_rx_ide = ~ide;
    o_rx_sid = ~sid;
    o_rx_eid = ~eid;
  endtask
endmodule
`default_nettype wire

// file: cidf_id_filter_flags_tb.sv
`default_nettype none
// ==========================================================
// testbench: register port, filtering and error flags
module cidf_id_filter_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, wr, rd, rvalid, opt, rx_valid, rx_ide, done, acc_info, acc_in, ovf, rcv, ack;
  logic [7:0]  addr, wdata, rdata, rec, flags, v;
  logic [8:0]  tec;
  logic [10:0] rx_sid;
  logic [17:0] rx_eid;
  logic [23:0] tx_low;
  int          n_fail, check_count, cyc;
  // address, write data, read back
  logic [23:0] rg [17] = '{24'h14ffff, 24'h15ffeb, 24'h16ffff, 24'h17fff8, 24'h182424, 24'h197460,
    24'h1a0000, 24'h1b0707, 24'h1c2424, 24'h1d7e6a, 24'h1ebcbc, 24'h1fcdcd, 24'h23a5a5, 24'h275a5a,
    24'h2b3c3c, 24'h21ffeb, 24'h2cff00};
  // option, ide, sid, eid, verdict {info, input}
  logic [32:0] fr [8] = '{{2'b00, 11'h123, 18'h0, 2'b10}, {2'b00, 11'h124, 18'h0, 2'b10},
    {2'b00, 11'h12b, 18'h0, 2'b00}, {2'b10, 11'h12b, 18'h0, 2'b10}, {2'b01, 11'h123, 18'h2bccd, 2'b01},
    {2'b01, 11'h123, 18'h2bcca, 2'b01}, {2'b01, 11'h124, 18'h2bccd, 2'b01}, {2'b01, 11'h123, 18'h2bcc5, 2'b00}};
  // tec, rec, overflow, recovered, ack, flags
  logic [27:0] fl [11] = '{{9'h05f, 8'h00, 3'b000, 8'h00}, {9'h060, 8'h00, 3'b000, 8'h05},
    {9'h080, 8'h00, 3'b000, 8'h95}, {9'h080, 8'h60, 3'b000, 8'h97}, {9'h080, 8'h60, 3'b001, 8'h17},
    {9'h100, 8'h60, 3'b000, 8'hb7}, {9'h000, 8'h60, 3'b000, 8'ha3}, {9'h000, 8'h60, 3'b010, 8'h83},
    {9'h000, 8'h60, 3'b100, 8'hc3}, {9'h000, 8'h60, 3'b001, 8'h03}, {9'h000, 8'h00, 3'b000, 8'h00}};
  cidf_id_filter_flags i_cidf_id_filter_flags (.i_clk_sys(clk), .i_rst_n(rst_n), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_message_type_option(opt), .i_rx_valid(rx_valid), .i_rx_ide(rx_ide), .i_rx_sid(rx_sid),
    .i_rx_eid(rx_eid), .o_rx_done(done), .o_accept_info(acc_info), .o_accept_input(acc_in), .i_tec(tec),
    .i_rec(rec), .i_rx_overflow(ovf), .i_bus_recovered(rcv), .i_flags_ack(ack), .o_bus_error_flags(flags),
    .o_tx_ident_ext_low(tx_low));
  cidf_partner i_cidf_partner (.i_clk_sys(clk), .o_rx_valid(rx_valid), .o_rx_ide(rx_ide),
    .o_rx_sid(rx_sid), .o_rx_eid(rx_eid));
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // register write, one edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1 wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  // register read, answer one edge later
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    d = rdata;
    @(posedge clk);
    #1;
  endtask
  // one frame through the filters
  task automatic fchk(input logic ide, input logic [10:0] sid, input logic [17:0] eid, input logic [1:0] exp);
    i_cidf_partner.send(ide, sid, eid);
    chk("verdict", {done, acc_info, acc_in}, {1'b1, exp});
    @(posedge clk);
    #1;
  endtask
  // counts and events, flags one edge later
  task automatic fstep(input logic [27:0] r);
    {tec, rec, ovf, rcv, ack} = r[27:8];
    @(posedge clk);
    #1 {ovf, rcv, ack} = 3'b000;
    chk("flags", flags, r[7:0]);
    @(posedge clk);
    #1;
  endtask
  // verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      results;
    end
  end
  // main sequence
  initial
  begin
    {rst_n, wr, rd, opt, ovf, rcv, ack, addr, wdata, tec, rec} = '0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    rd_reg(8'h2c, v);
    chk("flags reset", v, 8'h00);
    foreach (rg[i])
    begin
      wr_reg(rg[i][23:16], rg[i][15:8]);
      rd_reg(rg[i][23:16], v);
      chk("register", v, rg[i][7:0]);
    end
    chk("tx low bytes", tx_low, 24'h3c5aa5);
    foreach (fr[i])
    begin
      opt = fr[i][32];
      fchk(fr[i][31], fr[i][30:20], fr[i][19:2], fr[i][1:0]);
    end
    opt = 1'b0;
    wr_reg(8'h15, 8'he3);
    fchk(1'b1, 11'h124, 18'h0, 2'b00);
    fchk(1'b1, 11'h123, 18'h0, 2'b10);
    fchk(1'b0, 11'h123, 18'h0, 2'b11);
    foreach (fl[i])
      fstep(fl[i]);
    results;
  end
endmodule
`default_nettype wire
